// ==== rtl/dcv_chan_view.sv ====
// Channel control, loop counters, debug injection and build configuration
`timescale 1ns/100ps
`include "dcv_map.svh"
module dcv_chan_view (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic manager_nonsecure_at_reset_i,
  input wire logic start_from_counter_at_reset_i,
  input wire logic [31:0] boot_addr_i,
  input wire logic [31:0] boot_event_ns_i,
  input wire logic [31:0] boot_periph_ns_i,
  input wire logic ccr_wr_i,
  input wire logic [2:0] ccr_ch_i,
  input wire logic [31:0] ccr_data_i,
  input wire logic lc_wr_i,
  input wire logic lc_dec_i,
  input wire logic lc_sel_i,
  input wire logic [2:0] lc_ch_i,
  input wire logic [7:0] lc_data_i,
  input wire logic ld_req_i,
  input wire logic [2:0] ld_ch_i,
  input wire logic [31:0] ld_addr_i,
  output logic ld_ready_o,
  output logic [11:0] ld_bytes_o,
  input wire logic st_req_i,
  input wire logic [2:0] st_ch_i,
  input wire logic [31:0] st_addr_i,
  output logic st_ready_o,
  output logic [11:0] st_bytes_o,
  output logic arvalid_o,
  input wire logic arready_i,
  output logic [31:0] araddr_o,
  output logic [3:0] arlen_o,
  output logic [2:0] arsize_o,
  output logic [1:0] arburst_o,
  output logic [3:0] arcache_o,
  output logic [2:0] arprot_o,
  input wire logic rlast_done_i,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] awaddr_o,
  output logic [3:0] awlen_o,
  output logic [2:0] awsize_o,
  output logic [1:0] awburst_o,
  output logic [3:0] awcache_o,
  output logic [2:0] awprot_o,
  input wire logic bresp_done_i,
  output logic dbg_valid_o,
  input wire logic dbg_ready_i,
  output logic dbg_thread_o,
  output logic [2:0] dbg_chan_o,
  output logic [47:0] dbg_bytes_o,
  input wire logic dbg_done_i
);
  localparam int NCH = `DCV_NUM_CH;

  logic [31:0] ccr_ff [NCH];
  logic [7:0] lca_ff [NCH];
  logic [7:0] lcb_ff [NCH];

  // Storage per channel; engine loads control and loop counters
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          ccr_ff[g] <= 32'h00000000;
          lca_ff[g] <= 8'h00;
          lcb_ff[g] <= 8'h00;
        end else begin
          if (ccr_wr_i && ccr_ch_i == 3'(g)) begin
            ccr_ff[g] <= {4'h0, ccr_data_i[`DCV_CCR_USED-1:0]};
          end
          if (lc_ch_i == 3'(g)) begin
            if (lc_wr_i && !lc_sel_i) lca_ff[g] <= lc_data_i;
            else if (lc_dec_i && !lc_sel_i) lca_ff[g] <= lca_ff[g] - 8'h01;
            if (lc_wr_i && lc_sel_i) lcb_ff[g] <= lc_data_i;
            else if (lc_dec_i && lc_sel_i) lcb_ff[g] <= lcb_ff[g] - 8'h01;
          end
        end
      end
    end
  endgenerate

  // Straps cross in through two flops before being captured
  localparam int SW = 98;
  logic [SW-1:0] strap_s1_ff;
  logic [SW-1:0] strap_s2_ff;
  logic [1:0] cap_cnt_ff;
  logic mgr_ns_ff;
  logic pc_boot_ff;
  logic [31:0] boot_addr_ff;
  logic [31:0] event_ns_ff;
  logic [31:0] periph_ns_ff;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
    end else begin
      strap_s1_ff <= {manager_nonsecure_at_reset_i, start_from_counter_at_reset_i,
                      boot_addr_i, boot_event_ns_i, boot_periph_ns_i};
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Capture once the synchroniser holds post-release levels
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cap_cnt_ff <= 2'h0;
      mgr_ns_ff <= 1'b0;
      pc_boot_ff <= 1'b0;
      boot_addr_ff <= 32'h00000000;
      event_ns_ff <= `DCV_CFG3_RST;
      periph_ns_ff <= `DCV_CFG4_RST;
    end else if (cap_cnt_ff != 2'h3) begin
      cap_cnt_ff <= cap_cnt_ff + 2'h1;
      if (cap_cnt_ff == 2'h2) begin
        mgr_ns_ff <= strap_s2_ff[97];
        pc_boot_ff <= strap_s2_ff[96];
        boot_addr_ff <= strap_s2_ff[95:64];
        event_ns_ff <= strap_s2_ff[63:32];
        periph_ns_ff <= strap_s2_ff[31:0];
      end
    end
  end

  // Debug injection
  dcv_pkg::dcv_dbg_state_t dbg_st_ff;
  logic [31:0] inst0_ff;
  logic [31:0] inst1_ff;
  logic wr_acc;
  logic cmd_go;
  dcv_buf_if dbuf ();

  assign pready_o = 1'b1;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  // Reserved codes and commands while busy are dropped
  assign cmd_go = wr_acc && paddr_i == `DCV_OFF_DBGCMD && dbg_st_ff == dcv_pkg::DBG_IDLE
                  && pwdata_i[1:0] == `DCV_CMD_EXEC;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      inst0_ff <= 32'h00000000;
      inst1_ff <= 32'h00000000;
    end else if (wr_acc) begin
      if (paddr_i == `DCV_OFF_DBGWORD0) inst0_ff <= pwdata_i;
      if (paddr_i == `DCV_OFF_DBGWORD1) inst1_ff <= pwdata_i;
    end
  end

  assign dbuf.in_valid = cmd_go;
  assign dbuf.in_data.thread = inst0_ff[`DCV_INST0_THR];
  assign dbuf.in_data.chan = inst0_ff[`DCV_INST0_CH];
  assign dbuf.in_data.bytes = {inst1_ff, inst0_ff[`DCV_INST0_B1],
                               inst0_ff[`DCV_INST0_B0]};
  assign dbuf.out_ready = dbg_ready_i;
  assign dbg_valid_o = dbuf.out_valid;
  assign dbg_thread_o = dbuf.out_data.thread;
  assign dbg_chan_o = dbuf.out_data.chan;
  assign dbg_bytes_o = dbuf.out_data.bytes;

  dcv_two_buf u_buf (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .bus(dbuf.store)
  );

  // Busy covers queued time so a second command cannot overrun the buffer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dbg_st_ff <= dcv_pkg::DBG_IDLE;
    end else begin
      case (dbg_st_ff)
        dcv_pkg::DBG_IDLE: if (cmd_go && dbuf.in_ready) dbg_st_ff <= dcv_pkg::DBG_QUEUED;
        dcv_pkg::DBG_QUEUED: begin
          if (dbuf.out_valid && dbg_ready_i) dbg_st_ff <= dcv_pkg::DBG_EXEC;
        end
        dcv_pkg::DBG_EXEC: if (dbg_done_i) dbg_st_ff <= dcv_pkg::DBG_IDLE;
        default: dbg_st_ff <= dcv_pkg::DBG_IDLE;
      endcase
    end
  end

  // Read and write address issue
  logic [31:0] ld_ccr;
  logic [31:0] st_ccr;
  logic [2:0] rd_out_ff;
  logic [2:0] wr_out_ff;
  logic rd_room;
  logic wr_room;
  logic ar_take;
  logic aw_take;

  assign ld_ccr = (ld_ch_i < 3'(NCH)) ? ccr_ff[ld_ch_i] : 32'h00000000;
  assign st_ccr = (st_ch_i < 3'(NCH)) ? ccr_ff[st_ch_i] : 32'h00000000;
  assign rd_room = (rd_out_ff <= `DCV_CFGD_RCAP);
  assign wr_room = (wr_out_ff <= `DCV_CFGD_WCAP);
  assign ld_ready_o = !arvalid_o && rd_room;
  assign st_ready_o = !awvalid_o && wr_room;
  assign ar_take = ld_req_i && ld_ready_o;
  assign aw_take = st_req_i && st_ready_o;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      arvalid_o <= 1'b0;
      araddr_o <= 32'h00000000;
      arlen_o <= 4'h0;
      arsize_o <= 3'h0;
      arburst_o <= 2'h0;
      arcache_o <= 4'h0;
      arprot_o <= 3'h0;
      ld_bytes_o <= 12'h000;
    end else if (ar_take) begin
      arvalid_o <= 1'b1;
      araddr_o <= ld_addr_i;
      arlen_o <= ld_ccr[`DCV_CCR_SLEN];
      arsize_o <= ld_ccr[`DCV_CCR_SSIZE];
      arburst_o <= {1'b0, ld_ccr[`DCV_CCR_SINC]};
      arcache_o <= {1'b0, ld_ccr[`DCV_CCR_ARCACHE]};
      arprot_o <= ld_ccr[`DCV_CCR_ARPROT];
      ld_bytes_o <= 12'({8'h00, ld_ccr[`DCV_CCR_SLEN]} + 12'h001)
                    << ld_ccr[`DCV_CCR_SSIZE];
    end else if (arready_i) begin
      arvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      awvalid_o <= 1'b0;
      awaddr_o <= 32'h00000000;
      awlen_o <= 4'h0;
      awsize_o <= 3'h0;
      awburst_o <= 2'h0;
      awcache_o <= 4'h0;
      awprot_o <= 3'h0;
      st_bytes_o <= 12'h000;
    end else if (aw_take) begin
      awvalid_o <= 1'b1;
      awaddr_o <= st_addr_i;
      awlen_o <= st_ccr[`DCV_CCR_DLEN];
      awsize_o <= st_ccr[`DCV_CCR_DSIZE];
      awburst_o <= {1'b0, st_ccr[`DCV_CCR_DINC]};
      awcache_o <= {st_ccr[`DCV_CCR_AWCACHE3], 1'b0,
                    st_ccr[`DCV_CCR_AWCACHE10]};
      awprot_o <= st_ccr[`DCV_CCR_AWPROT];
      st_bytes_o <= 12'({8'h00, st_ccr[`DCV_CCR_DLEN]} + 12'h001)
                    << st_ccr[`DCV_CCR_DSIZE];
    end else if (awready_i) begin
      awvalid_o <= 1'b0;
    end
  end

  // Outstanding counts rise on address issue, fall on completion
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_out_ff <= 3'h0;
      wr_out_ff <= 3'h0;
    end else begin
      if (ar_take && !rlast_done_i) rd_out_ff <= rd_out_ff + 3'h1;
      else if (!ar_take && rlast_done_i && rd_out_ff != 3'h0) rd_out_ff <= rd_out_ff - 3'h1;
      if (aw_take && !bresp_done_i) wr_out_ff <= wr_out_ff + 3'h1;
      else if (!aw_take && bresp_done_i && wr_out_ff != 3'h0) wr_out_ff <= wr_out_ff - 3'h1;
    end
  end

  // Register read path, sampled in setup so data is ready in access
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic [11:0] ch_off;
  logic [2:0] ch_idx;

  assign ch_off = paddr_i - `DCV_OFF_CCR0;
  assign ch_idx = ch_off[7:5];

  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    if (paddr_i >= `DCV_OFF_CCR0 && ch_off < 12'(NCH) * `DCV_CH_STRIDE
        && ch_off[4:0] <= 5'h08 && ch_off[1:0] == 2'h0) begin
      case (ch_off[4:0])
        5'h00: nxt_rdata = ccr_ff[ch_idx];
        5'h04: nxt_rdata = {24'h000000, lca_ff[ch_idx]};
        5'h08: nxt_rdata = {24'h000000, lcb_ff[ch_idx]};
        default: nxt_err = 1'b1;
      endcase
      nxt_err = nxt_err || pwrite_i;
    end else begin
      case (paddr_i)
        `DCV_OFF_DBGSTATE: nxt_rdata = {31'h0, dbg_st_ff != dcv_pkg::DBG_IDLE};
        `DCV_OFF_DBGCMD, `DCV_OFF_DBGWORD0, `DCV_OFF_DBGWORD1: nxt_rdata = 32'h00000000;
        `DCV_OFF_CFG0: nxt_rdata = {10'h000, `DCV_CFG0_NIRQ, `DCV_CFG0_NPER, 5'h00,
                                    `DCV_CFG0_NCH, 1'b0, mgr_ns_ff, pc_boot_ff,
                                    `DCV_CFG0_PERIPH};
        `DCV_OFF_CFG1: nxt_rdata = {24'h000000, `DCV_CFG1_LINES, 1'b0,
                                    `DCV_CFG1_LEN};
        `DCV_OFF_CFG2: nxt_rdata = boot_addr_ff;
        `DCV_OFF_CFG3: nxt_rdata = event_ns_ff;
        `DCV_OFF_CFG4: nxt_rdata = periph_ns_ff;
        `DCV_OFF_CFGD: nxt_rdata = {2'h0, `DCV_CFGD_BUFL, `DCV_CFGD_RQ, 1'b0,
                                    `DCV_CFGD_RCAP, `DCV_CFGD_WQ, 1'b0,
                                    `DCV_CFGD_WCAP, 4'h0};
        default: nxt_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_o <= pwrite_i ? 32'h00000000 : nxt_rdata;
      pslverr_o <= nxt_err;
    end
  end
endmodule

// ==== rtl/dcv_map.svh ====
// Register offsets, field positions, reset values and limits of the channel view
`ifndef DCV_MAP_SVH
`define DCV_MAP_SVH

`define DCV_NUM_CH 6
`define DCV_ADDR_W 12
`define DCV_OFF_CCR0 12'h408
`define DCV_OFF_LCA0 12'h40C
`define DCV_OFF_LCB0 12'h410
`define DCV_CH_STRIDE 12'h020
`define DCV_OFF_DBGSTATE 12'hD00
`define DCV_OFF_DBGCMD 12'hD04
`define DCV_OFF_DBGWORD0 12'hD08
`define DCV_OFF_DBGWORD1 12'hD0C
`define DCV_OFF_CFG0 12'hE00
`define DCV_OFF_CFG1 12'hE04
`define DCV_OFF_CFG2 12'hE08
`define DCV_OFF_CFG3 12'hE0C
`define DCV_OFF_CFG4 12'hE10
`define DCV_OFF_CFGD 12'hE14

`define DCV_CCR_AWCACHE3 27
`define DCV_CCR_AWCACHE10 26:25
`define DCV_CCR_AWPROT 24:22
`define DCV_CCR_DLEN 21:18
`define DCV_CCR_DSIZE 17:15
`define DCV_CCR_DINC 14
`define DCV_CCR_ARCACHE 13:11
`define DCV_CCR_ARPROT 10:8
`define DCV_CCR_SLEN 7:4
`define DCV_CCR_SSIZE 3:1
`define DCV_CCR_SINC 0
`define DCV_CCR_USED 28

`define DCV_CMD_EXEC 2'h0
`define DCV_INST0_B1 31:24
`define DCV_INST0_B0 23:16
`define DCV_INST0_CH 10:8
`define DCV_INST0_THR 0

`define DCV_CFG0_NIRQ 5'h02
`define DCV_CFG0_NPER 5'h07
`define DCV_CFG0_NCH 3'h5
`define DCV_CFG0_PERIPH 1'h1
`define DCV_CFG1_LINES 4'h5
`define DCV_CFG1_LEN 3'h7
`define DCV_CFG3_RST 32'h00000000
`define DCV_CFG4_RST 32'h00000006
`define DCV_CFGD_BUFL 10'h020
`define DCV_CFGD_RQ 4'h9
`define DCV_CFGD_RCAP 3'h4
`define DCV_CFGD_WQ 4'h7
`define DCV_CFGD_WCAP 3'h3

`endif

// ==== rtl/dcv_pkg.sv ====
// Types shared by the channel view modules
package dcv_pkg;
  typedef struct packed {
    logic thread;
    logic [2:0] chan;
    logic [47:0] bytes;
  } dcv_dbg_inst_t;
  typedef enum logic [1:0] {DBG_IDLE, DBG_QUEUED, DBG_EXEC} dcv_dbg_state_t;
endpackage

// ==== rtl/dcv_buf_if.sv ====
// Valid/ready carrier between the register block and its two-entry buffer
`timescale 1ns/100ps
interface dcv_buf_if;
  logic in_valid;
  logic in_ready;
  dcv_pkg::dcv_dbg_inst_t in_data;
  logic out_valid;
  logic out_ready;
  dcv_pkg::dcv_dbg_inst_t out_data;
  modport store (input in_valid, output in_ready, input in_data,
                 output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface

// ==== rtl/dcv_two_buf.sv ====
// Two-entry buffer for injected debug instructions
`timescale 1ns/100ps
module dcv_two_buf (
  input wire logic core_clk_i,
  input wire logic reset_i,
  dcv_buf_if.store bus
);
  dcv_pkg::dcv_dbg_inst_t mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  assign bus.in_ready = (cnt_ff != 2'h2);
  assign bus.out_valid = (cnt_ff != 2'h0);
  assign bus.out_data = mem_ff[rd_ptr_ff];
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= bus.in_data;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop) cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push) cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule

// ==== testbench/dcv_checker.sv ====
// Assertions on the channel view top ports
`timescale 1ns/100ps
`include "dcv_map.svh"
module dcv_checker (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic ccr_wr_i,
  input wire logic [2:0] ccr_ch_i,
  input wire logic [31:0] ccr_data_i,
  input wire logic ld_req_i,
  input wire logic [2:0] ld_ch_i,
  input wire logic ld_ready_o,
  input wire logic st_req_i,
  input wire logic [2:0] st_ch_i,
  input wire logic st_ready_o,
  input wire logic arvalid_o,
  input wire logic [3:0] arlen_o,
  input wire logic [2:0] arsize_o,
  input wire logic [1:0] arburst_o,
  input wire logic [3:0] arcache_o,
  input wire logic [2:0] arprot_o,
  input wire logic rlast_done_i,
  input wire logic awvalid_o,
  input wire logic [3:0] awlen_o,
  input wire logic [2:0] awsize_o,
  input wire logic [1:0] awburst_o,
  input wire logic [3:0] awcache_o,
  input wire logic [2:0] awprot_o,
  input wire logic bresp_done_i,
  input wire logic dbg_valid_o,
  input wire logic dbg_ready_i,
  input wire logic dbg_thread_o,
  input wire logic [2:0] dbg_chan_o,
  input wire logic [47:0] dbg_bytes_o,
  input wire logic dbg_done_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] sh_ff [6];
  logic [31:0] i0_ff, i1_ff;
  logic busy_ff;
  logic [3:0] rd_ff, wr_ff;
  wire cmd = psel_i && penable_i && pwrite_i && paddr_i == 12'hD04;
  wire go = cmd && pwdata_i[1:0] == 2'h0 && !busy_ff;
  wire [31:0] ldc = ld_ch_i < 3'h6 ? sh_ff[ld_ch_i] : 32'h0;
  wire [31:0] stc = st_ch_i < 3'h6 ? sh_ff[st_ch_i] : 32'h0;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 6; i++) sh_ff[i] <= 32'h0;
    end else if (ccr_wr_i && ccr_ch_i < 3'h6) begin
      sh_ff[ccr_ch_i] <= {4'h0, ccr_data_i[27:0]};
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {i0_ff, i1_ff, busy_ff} <= 65'h0;
    end else begin
      if (psel_i && penable_i && pwrite_i && paddr_i == 12'hD08) i0_ff <= pwdata_i;
      if (psel_i && penable_i && pwrite_i && paddr_i == 12'hD0C) i1_ff <= pwdata_i;
      busy_ff <= go || (busy_ff && !dbg_done_i);
    end
  end
  // Counted from the take, so the pending address phase is included
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {rd_ff, wr_ff} <= 8'h00;
    end else begin
      rd_ff <= rd_ff + 4'(ld_req_i && ld_ready_o) - 4'(rlast_done_i);
      wr_ff <= wr_ff + 4'(st_req_i && st_ready_o) - 4'(bresp_done_i);
    end
  end
  sequence s_ld;
    ld_req_i && ld_ready_o;
  endsequence
  sequence s_st;
    st_req_i && st_ready_o;
  endsequence
  a_ar_fields: assert property (s_ld |=> arvalid_o &&
    {arcache_o, arprot_o, arlen_o, arsize_o, arburst_o[0]} == {1'b0, $past(ldc[13:0])})
    else $error("read address fields wrong");
  a_aw_fields: assert property (s_st |=> awvalid_o &&
    {awcache_o, awprot_o, awlen_o, awsize_o, awburst_o[0]}
    == {$past(stc[27]), 1'b0, $past(stc[26:14])})
    else $error("write address fields wrong");
  a_rd_limit: assert property (!arvalid_o && !rlast_done_i |->
    ld_ready_o == (rd_ff < 4'h5)) else $error("read issue limit wrong");
  a_wr_limit: assert property (!awvalid_o && !bresp_done_i |->
    st_ready_o == (wr_ff < 4'h4)) else $error("write issue limit wrong");
  a_dbg_push: assert property (go |=> dbg_valid_o && dbg_bytes_o == {i1_ff, i0_ff[31:16]}
    && dbg_chan_o == i0_ff[10:8] && dbg_thread_o == i0_ff[0]) else $error("debug push wrong");
  a_dbg_hold: assert property (dbg_valid_o && !dbg_ready_i |=>
    dbg_valid_o && $stable(dbg_bytes_o)) else $error("debug word dropped");
  a_cmd_refuse: assert property (cmd && (busy_ff || pwdata_i[1:0] != 2'h0)
    && !dbg_valid_o |=> !dbg_valid_o) else $error("refused command pushed");
  a_lc_upper: assert property (psel_i && !penable_i && !pwrite_i && paddr_i[11:8] == 4'h4
    && paddr_i[7:5] < 3'h6 && (paddr_i[4:0] == 5'h0C || paddr_i[4:0] == 5'h10)
    |=> prdata_o[31:8] == 24'h0) else $error("loop count upper bits set");
endmodule

// ==== testbench/dcv_far_model.sv ====
// Far side: address ready, burst completions and the debug engine
`timescale 1ns/100ps
module dcv_far_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hold_i,
  input wire logic arvalid_i,
  input wire logic awvalid_i,
  input wire logic dbg_valid_i,
  output logic arready_o,
  output logic awready_o,
  output logic rdone_o,
  output logic wdone_o,
  output logic dbg_ready_o,
  output logic dbg_done_o
);
  int rd, wr;
  logic pend;
  // Ready never two cycles running, so prompt and slow answers mix
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {arready_o, awready_o, rdone_o, wdone_o, dbg_ready_o, dbg_done_o, pend} <= 7'h00;
      rd <= 0;
      wr <= 0;
    end else begin
      arready_o <= arvalid_i && !arready_o && 1'($urandom_range(1));
      awready_o <= awvalid_i && !awready_o && 1'($urandom_range(1));
      rd <= rd + int'(arvalid_i && arready_o) - int'(rdone_o);
      wr <= wr + int'(awvalid_i && awready_o) - int'(wdone_o);
      rdone_o <= !hold_i && !rdone_o && rd > 0 && 1'($urandom_range(1));
      wdone_o <= !hold_i && !wdone_o && wr > 0 && 1'($urandom_range(1));
      dbg_ready_o <= dbg_valid_i && !dbg_ready_o && !hold_i && 1'($urandom_range(1));
      pend <= (pend && !dbg_done_o) || (dbg_valid_i && dbg_ready_o);
      dbg_done_o <= pend && !dbg_done_o && !hold_i && 1'($urandom_range(1));
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the channel view
`timescale 1ns/100ps
module tb;
  logic core_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, hold = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, boot_addr_i, boot_event_ns_i, boot_periph_ns_i, q;
  logic pready_o, pslverr_o, manager_nonsecure_at_reset_i, start_from_counter_at_reset_i, e;
  logic ccr_wr_i = 0, lc_wr_i = 0, lc_dec_i = 0, lc_sel_i = 0, ld_req_i = 0, st_req_i = 0;
  logic [2:0] ccr_ch_i = '0, lc_ch_i = '0, ld_ch_i = '0, st_ch_i = '0;
  logic [31:0] ccr_data_i = '0, ld_addr_i = '0, st_addr_i = '0, araddr_o, awaddr_o;
  logic [7:0] lc_data_i = '0;
  logic ld_ready_o, st_ready_o, arvalid_o, arready_i, rlast_done_i, awvalid_o, awready_i;
  logic bresp_done_i, dbg_valid_o, dbg_ready_i, dbg_thread_o, dbg_done_i;
  logic [11:0] ld_bytes_o, st_bytes_o;
  logic [3:0] arlen_o, awlen_o, arcache_o, awcache_o;
  logic [2:0] arsize_o, awsize_o, arprot_o, awprot_o, dbg_chan_o;
  logic [1:0] arburst_o, awburst_o;
  logic [47:0] dbg_bytes_o;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  dcv_chan_view i_dut (.*);
  dcv_far_model i_far (.core_clk_i(core_clk_i), .reset_i(reset_i), .hold_i(hold),
    .arvalid_i(arvalid_o), .awvalid_i(awvalid_o), .dbg_valid_i(dbg_valid_o),
    .arready_o(arready_i), .awready_o(awready_i), .rdone_o(rlast_done_i),
    .wdone_o(bresp_done_i), .dbg_ready_o(dbg_ready_i), .dbg_done_o(dbg_done_i));
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [47:0] x, input logic [47:0] got);
    n_checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    #1 {psel_i, pwrite_i, paddr_i, pwdata_i} = {1'h1, w, a, d};
    @(posedge core_clk_i);
    #1 penable_i = 1'h1;
    @(posedge core_clk_i);
    q = prdata_o;
    e = pslverr_o;
    #1 {psel_i, penable_i} = 2'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, x, q);
  endtask
  task automatic burst(input logic w, input logic [2:0] ch, input logic [31:0] a);
    @(posedge core_clk_i);
    #1 if (w) {st_req_i, st_ch_i, st_addr_i} = {1'h1, ch, a};
    else {ld_req_i, ld_ch_i, ld_addr_i} = {1'h1, ch, a};
    @(posedge core_clk_i);
    while ((w ? st_ready_o : ld_ready_o) !== 1'h1) @(posedge core_clk_i);
    #1 {ld_req_i, st_req_i} = 2'h0;
  endtask
  function automatic logic [11:0] nbytes(input logic [3:0] len, input logic [2:0] sz);
    return ({8'h00, len} + 12'h001) << sz;
  endfunction
  initial begin
    logic [31:0] c, i0, i1;
    logic [31:0] x [6];
    logic [2:0] ch;
    logic [7:0] d;
    logic r;
    void'($urandom(18));
    {manager_nonsecure_at_reset_i, start_from_counter_at_reset_i} = 2'($urandom);
    {boot_addr_i, boot_event_ns_i, boot_periph_ns_i} = {$urandom, $urandom, $urandom};
    repeat (12) @(posedge core_clk_i);
    #1 reset_i = 1'h0;
    repeat (4) @(posedge core_clk_i);
    x = '{{10'h0, 5'h02, 5'h07, 5'h00, 3'h5, 1'h0, manager_nonsecure_at_reset_i,
      start_from_counter_at_reset_i, 1'h1}, {24'h0, 4'h5, 1'h0, 3'h7}, boot_addr_i,
      boot_event_ns_i, boot_periph_ns_i, {2'h0, 10'h020, 4'h9, 1'h0, 3'h4, 4'h7, 4'h3, 4'h0}};
    for (int k = 0; k < 6; k++) rdc(12'hE00 + 12'(4 * k), x[k], "config");
    apb(1'h1, 12'hE08, ~boot_addr_i);
    rdc(12'hE08, boot_addr_i, "config ro");
    apb(1'h0, 12'h800, 32'h0);
    chk("unmapped err", 1'h1, e);
    chk("pready", 1'h1, pready_o);
    $display("test config done");
    for (int k = 0; k < 10; k++) begin
      ch = 3'($urandom_range(5));
      c = k == 0 ? 32'hFFFFFFFF : (k == 1 ? 32'h0 : $urandom);
      {ccr_ch_i, ccr_data_i, ccr_wr_i} = {ch, c, 1'h1};
      @(posedge core_clk_i);
      #1 ccr_wr_i = 1'h0;
      rdc(12'h408 + {4'h0, ch, 5'h00}, {4'h0, c[27:0]}, "control");
      i0 = $urandom;
      burst(1'h0, ch, i0);
      chk("araddr", i0, araddr_o);
      chk("ar", {1'h0, c[13:0]}, {arcache_o, arprot_o, arlen_o, arsize_o, arburst_o[0]});
      chk("ld bytes", nbytes(c[7:4], c[3:1]), ld_bytes_o);
      i0 = $urandom;
      burst(1'h1, ch, i0);
      chk("awaddr", i0, awaddr_o);
      chk("aw", {c[27], 1'h0, c[26:14]}, {awcache_o, awprot_o, awlen_o, awsize_o, awburst_o[0]});
      chk("st bytes", nbytes(c[21:18], c[17:15]), st_bytes_o);
    end
    $display("test control done");
    for (int k = 0; k < 6; k++) begin
      ch = 3'($urandom_range(5));
      d = k == 0 ? 8'hFF : 8'($urandom_range(255, 1));
      {lc_ch_i, lc_sel_i, lc_data_i, lc_wr_i} = {ch, k[0], d, 1'h1};
      @(posedge core_clk_i);
      #1 {lc_wr_i, lc_dec_i} = 2'h1;
      @(posedge core_clk_i);
      #1 lc_dec_i = 1'h0;
      rdc(12'h40C + {4'h0, ch, 5'h00} + {9'h0, k[0], 2'h0}, {24'h0, d - 8'h01}, "loop");
    end
    apb(1'h1, 12'h40C, 32'h0);
    chk("loop ro err", 1'h1, e);
    $display("test loop done");
    for (int w = 0; w < 2; w++) begin
      // Design counts from the take, so pending address phases must drain too
      while (i_far.rd != 0 || i_far.wr != 0 || arvalid_o || awvalid_o) @(posedge core_clk_i);
      #1 hold = 1'h1;
      repeat (5 - w) burst(w[0], 3'h0, $urandom);
      @(posedge core_clk_i);
      #1 if (w) st_req_i = 1'h1;
      else ld_req_i = 1'h1;
      r = 1'h0;
      repeat (8) begin
        @(posedge core_clk_i);
        r = r | (w ? st_ready_o : ld_ready_o);
      end
      chk("ready at limit", 1'h0, r);
      #1 {ld_req_i, st_req_i, hold} = 3'h0;
      burst(w[0], 3'h0, 32'h0);
    end
    $display("test limit done");
    for (int k = 1; k < 4; k++) begin
      i0 = $urandom & 32'hFFFF0701;
      i1 = $urandom;
      apb(1'h1, 12'hD08, i0);
      apb(1'h1, 12'hD0C, i1);
      rdc(12'hD00, 32'h0, "dbg state");
      hold = 1'h1;
      apb(1'h1, 12'hD04, 32'(k));
      chk("dbg reserved", 1'h0, dbg_valid_o);
      apb(1'h1, 12'hD04, 32'h0);
      rdc(12'hD00, 32'h1, "dbg state");
      apb(1'h1, 12'hD08, ~i0);
      apb(1'h1, 12'hD04, 32'h0);
      chk("dbg bytes", {i1, i0[31:16]}, dbg_bytes_o);
      chk("dbg target", {i0[10:8], i0[0]}, {dbg_chan_o, dbg_thread_o});
      hold = 1'h0;
      q = 32'h1;
      while (q[0] !== 1'h0) apb(1'h0, 12'hD00, 32'h0);
      chk("dbg refused", 1'h0, dbg_valid_o);
    end
    $display("test debug done");
    finish_test();
  end
endmodule
bind dcv_chan_view dcv_checker i_chk (.*);
